//--- include/tcw_pkg.sv
// Package for the texture coordinate wrap and fetch stage
package tcw_pkg;

  // Register byte offsets
  localparam logic [11:0] COORD_GEN_CONTROL_OFS   = 12'h000;
  localparam logic [11:0] TEXEL_FETCH_CONTROL_OFS = 12'h004;
  localparam logic [11:0] TEX_BASE_OFS            = 12'h008;
  localparam logic [11:0] STATUS_OFS              = 12'h00C;

  // Coordinate generation control fields
  localparam int CGC_ENABLE_BIT = 0;
  localparam int CGC_HWRAP_LSB  = 1;
  localparam int CGC_FETCH_VERT_WRAP_LSB  = 3;
  localparam int CGC_OP_BIT     = 5;

  // Texel fetch control fields
  localparam int TFC_ENABLE_BIT = 0;
  localparam int TFC_WIDTH_LSB  = 1;
  localparam int TFC_HEIGHT_LSB = 5;
  localparam int TFC_MAG_BIT    = 9;
  localparam int TFC_MIN_LSB    = 10;
  localparam int TFC_FETCH_HORIZ_WRAP_LSB  = 13;
  localparam int TFC_FETCH_VERT_WRAP_LSB  = 15;
  localparam int TFC_MAPTYPE_BIT = 17;

  // Reset values
  localparam logic [31:0] CGC_RESET  = 32'h0000_0000;
  localparam logic [31:0] TFC_RESET  = 32'h0000_0000;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;

  // Pipeline latency of the perspective divider, in cycles
  localparam int DIV_CYCLES = 2;

  typedef enum logic [1:0] {
    TCW_CLAMP  = 2'b00,
    TCW_REPEAT = 2'b01,
    TCW_MIRROR = 2'b10
  } tcw_wrap_e;

  typedef enum logic [2:0] {
    TCW_MIN_NEAREST   = 3'b000,
    TCW_MIN_LINEAR    = 3'b001,
    TCW_MIN_NMN       = 3'b010,
    TCW_MIN_NML       = 3'b011,
    TCW_MIN_LMN       = 3'b100,
    TCW_MIN_LML       = 3'b101
  } tcw_minf_e;

  // Incoming fragment: S,T,Q as signed 16.16 in perspective mode, S,T as unsigned 0.32 in planar mode
  typedef struct packed {
    logic [31:0] s;
    logic [31:0] t;
    logic [31:0] q;
    logic        tex_en;
    logic        line;
  } tcw_frag_s;

  // Texel forwarded downstream: four texels, 8 bits per component
  typedef struct packed {
    logic [3:0][31:0] texel;
    logic [7:0]       coef_u;
    logic [7:0]       coef_v;
    logic [1:0]       ntex;
  } tcw_texout_s;

endpackage

//--- design/tcw_divider.sv
// Pipelined signed 16.16 divide of S and T by Q
`timescale 1ns/1ps
module tcw_divider (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        in_valid,
  input  wire logic [31:0] num_s,
  input  wire logic [31:0] num_t,
  input  wire logic [31:0] den_q,
  output logic             out_valid,
  output logic [31:0]      quo_s,
  output logic [31:0]      quo_t
);

  logic        v_q;
  logic [31:0] qs_q;
  logic [31:0] qt_q;

  // Signed quotient in 16.16, zero denominator gives zero
  function automatic logic [31:0] fx_div(input logic [31:0] n, input logic [31:0] d);
    logic signed [63:0] nn;
    logic signed [63:0] r;
    nn = {{16{n[31]}}, n, 16'h0000};
    if (d == 32'h0000_0000) begin
      r = 64'sh0;
    end else begin
      r = nn / $signed({{32{d[31]}}, d});
    end
    return r[31:0];
  endfunction

  // Stage one divides, stage two registers the result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v_q       <= 1'b0;
      qs_q      <= 32'h0000_0000;
      qt_q      <= 32'h0000_0000;
      out_valid <= 1'b0;
      quo_s     <= 32'h0000_0000;
      quo_t     <= 32'h0000_0000;
    end else begin
      v_q       <= in_valid;
      qs_q      <= fx_div(num_s, den_q);
      qt_q      <= fx_div(num_t, den_q);
      out_valid <= v_q;
      quo_s     <= qs_q;
      quo_t     <= qt_q;
    end
  end

endmodule

//--- design/tcw_texmem.sv
// Small texel memory with registered read data, four read ports
`timescale 1ns/1ps
module tcw_texmem (
  input  wire logic             pclk,
  input  wire logic             we,
  input  wire logic [7:0]       waddr,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0][7:0]  raddr,
  output logic      [3:0][31:0] rdata
);

  logic [31:0] mem [256];

  // Write port
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read ports
  for (genvar i = 0; i < 4; i++) begin : g_rd
    always_ff @(posedge pclk) begin
      rdata[i] <= mem[raddr[i]];
    end
  end

endmodule

//--- design/tcw_top.sv
// Texture coordinate generation, wrap and texel fetch with APB registers
`timescale 1ns/1ps

// Functional notes
// RQ1: Clamp mode limits coordinate to the range 0.0 through 1.0.
// RQ2: Repeat mode keeps only the fractional part of the coordinate.
// RQ3: Mirror uses fraction on even integer part, one minus fraction on odd.
// RQ4: Three wrap modes, selected separately for s and t.
// RQ5: Fetch control holds horizontal and vertical wrap copies too.
// RQ6: Enable bit clear means no coordinates are generated.
// RQ7: Generate only when enable bit and primitive texture enable both set.
// RQ8: Horizontal selection wraps s into u.
// RQ9: Vertical selection wraps t into v.
// RQ10: Operation bit clear gives planar mode without dividing by Q.
// RQ11: Operation bit set divides S and T by Q per fragment before wrap.
// RQ12: Planar mode always repeats via unsigned 0.32 natural overflow.
// RQ13: Planar mode must not be slower than perspective mode.
// RQ14: Read stage forms texel memory addresses from wrapped u,v.
// RQ15: Texels are expanded to 8 bits per colour component.
// RQ16: Interpolation coefficients derived from u,v go with the texels.
// RQ17: Six minification and two magnification filters are supported.
// RQ18: Nearest filter uses the single closest texel without blending.
// RQ19: Linear filter on lines uses the two nearest texels.
// RQ20: Linear filter on polygons and points uses four surrounding texels.
// RQ21: Wrapped coordinates lie within 0.0 to 1.0 inclusive.
// RQ22: Wrap code clamp is 0, repeat is 1, mirror is 2.
// RQ23: Negative coordinates take the floor as integer part.
module tcw_top (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               frag_valid,
  output logic                    frag_ready,
  input  wire tcw_pkg::tcw_frag_s frag,
  input  wire logic               minify,
  input  wire logic               tmem_we,
  input  wire logic [7:0]         tmem_waddr,
  input  wire logic [31:0]        tmem_wdata,
  output logic                    tex_valid,
  output tcw_pkg::tcw_texout_s    tex_out,
  output logic [3:0][7:0]         tex_addr
);

  logic [31:0] cgc_q;
  logic [31:0] tfc_q;
  logic [31:0] base_q;
  logic [31:0] frag_cnt_q;

  logic        apb_acc;
  logic        apb_wr;

  assign apb_acc    = psel && penable;
  assign apb_wr     = apb_acc && pwrite;
  assign pready     = 1'b1;

  // Register map decode, shared by the error answer and the write path
  function automatic logic reg_mapped(input logic [11:0] a);
    return a == tcw_pkg::COORD_GEN_CONTROL_OFS ||
           a == tcw_pkg::TEXEL_FETCH_CONTROL_OFS ||
           a == tcw_pkg::TEX_BASE_OFS ||
           a == tcw_pkg::STATUS_OFS;
  endfunction

  // Unmapped addresses answer with an error
  assign pslverr = apb_acc && !reg_mapped(paddr);

  // Register writes; wrap copies kept in both control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cgc_q  <= tcw_pkg::CGC_RESET;
      tfc_q  <= tcw_pkg::TFC_RESET;
      base_q <= tcw_pkg::BASE_RESET;
    end else if (apb_wr && reg_mapped(paddr)) begin
      unique case (paddr)
        tcw_pkg::COORD_GEN_CONTROL_OFS: begin
          cgc_q <= {26'h0, pwdata[5:0]};
          tfc_q[tcw_pkg::TFC_FETCH_HORIZ_WRAP_LSB +: 2] <= pwdata[tcw_pkg::CGC_HWRAP_LSB +: 2]; // [RQ5]
          tfc_q[tcw_pkg::TFC_FETCH_VERT_WRAP_LSB +: 2] <= pwdata[tcw_pkg::CGC_FETCH_VERT_WRAP_LSB +: 2]; // [RQ5]
        end
        tcw_pkg::TEXEL_FETCH_CONTROL_OFS: begin
          tfc_q <= {14'h0, pwdata[17:0]};
          cgc_q[tcw_pkg::CGC_HWRAP_LSB +: 2] <= pwdata[tcw_pkg::TFC_FETCH_HORIZ_WRAP_LSB +: 2]; // [RQ5]
          cgc_q[tcw_pkg::CGC_FETCH_VERT_WRAP_LSB +: 2] <= pwdata[tcw_pkg::TFC_FETCH_VERT_WRAP_LSB +: 2]; // [RQ5]
        end
        tcw_pkg::TEX_BASE_OFS: begin
          base_q <= {24'h0, pwdata[7:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Read data mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        tcw_pkg::COORD_GEN_CONTROL_OFS:   prdata <= cgc_q;
        tcw_pkg::TEXEL_FETCH_CONTROL_OFS: prdata <= tfc_q;
        tcw_pkg::TEX_BASE_OFS:            prdata <= base_q;
        tcw_pkg::STATUS_OFS:              prdata <= frag_cnt_q;
        default:                          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control decode
  logic        gen_en;
  logic        persp;
  logic [1:0]  hwrap;
  logic [1:0]  fetch_vert_wrap;
  logic        accept;

  assign gen_en = cgc_q[tcw_pkg::CGC_ENABLE_BIT];
  assign persp  = cgc_q[tcw_pkg::CGC_OP_BIT];
  assign hwrap  = cgc_q[tcw_pkg::CGC_HWRAP_LSB +: 2];
  assign fetch_vert_wrap  = cgc_q[tcw_pkg::CGC_FETCH_VERT_WRAP_LSB +: 2];
  assign accept = frag_valid && gen_en && frag.tex_en; // [RQ6] [RQ7]

  // Wrap one signed 16.16 coordinate to unsigned 1.16 in 0.0..1.0
  function automatic logic [16:0] wrap_coord(input logic [31:0] c, input logic [1:0] m);
    logic [16:0] r;
    r = 17'h0_0000;
    unique case (m)
      tcw_pkg::TCW_CLAMP: begin
        if (c[31]) begin
          r = 17'h0_0000; // [RQ1]
        end else if (c[30:16] != 15'h0000) begin
          r = 17'h1_0000; // [RQ1]
        end else begin
          r = {1'b0, c[15:0]};
        end
      end
      tcw_pkg::TCW_MIRROR: begin
        // Two's complement low bits already give the floor fraction
        if (c[16]) begin
          r = 17'h1_0000 - {1'b0, c[15:0]}; // [RQ3] [RQ23]
        end else begin
          r = {1'b0, c[15:0]}; // [RQ3]
        end
      end
      default: begin
        r = {1'b0, c[15:0]}; // [RQ2] [RQ23]
      end
    endcase
    return r;
  endfunction

  // Perspective path through the divider
  logic        div_valid;
  logic [31:0] div_s;
  logic [31:0] div_t;
  logic        dline_q [tcw_pkg::DIV_CYCLES];
  logic        dtake_q [tcw_pkg::DIV_CYCLES];

  tcw_divider u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (accept && persp),
    .num_s     (frag.s),
    .num_t     (frag.t),
    .den_q     (frag.q),
    .out_valid (div_valid),
    .quo_s     (div_s),
    .quo_t     (div_t)
  ); // [RQ11]

  // Line flag follows the divider pipeline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dline_q[0] <= 1'b0;
      dline_q[1] <= 1'b0;
      dtake_q[0] <= 1'b0;
      dtake_q[1] <= 1'b0;
    end else begin
      dline_q[0] <= frag.line;
      dline_q[1] <= dline_q[0];
      dtake_q[0] <= accept && persp;
      dtake_q[1] <= dtake_q[0];
    end
  end

  // Planar path: 0.32 fraction wraps by overflow, always repeat, one cycle
  logic [16:0] pu;
  logic [16:0] pv;
  logic [16:0] qu;
  logic [16:0] qv;
  assign pu = {1'b0, frag.s[31:16]}; // [RQ10] [RQ12]
  assign pv = {1'b0, frag.t[31:16]}; // [RQ10] [RQ12]
  assign qu = wrap_coord(div_s, hwrap); // [RQ4] [RQ8] [RQ22]
  assign qv = wrap_coord(div_t, fetch_vert_wrap); // [RQ4] [RQ9] [RQ22]

  // Wrapped coordinate stage; divider output wins, planar enters otherwise
  logic        uv_valid_q;
  logic [16:0] u_q;
  logic [16:0] v_q;
  logic        uv_line_q;
  logic        planar_hold;

  // Planar fragment colliding with a divider result is refused this cycle
  assign planar_hold = accept && !persp && div_valid && dtake_q[1];

  // Ready drops while a divider result owns the wrapped stage in planar mode
  assign frag_ready = !(div_valid && dtake_q[1] && !persp); // [RQ13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_valid_q <= 1'b0;
      u_q        <= 17'h0_0000;
      v_q        <= 17'h0_0000;
      uv_line_q  <= 1'b0;
    end else if (div_valid && dtake_q[1]) begin
      uv_valid_q <= 1'b1;
      u_q        <= qu; // [RQ21]
      v_q        <= qv; // [RQ21]
      uv_line_q  <= dline_q[1];
    end else if (accept && !persp) begin
      uv_valid_q <= 1'b1; // [RQ13]
      u_q        <= pu;
      v_q        <= pv;
      uv_line_q  <= frag.line;
    end else begin
      uv_valid_q <= 1'b0;
    end
  end

  // Fragment counter visible in status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frag_cnt_q <= 32'h0000_0000;
    end else if (accept && !planar_hold) begin
      frag_cnt_q <= frag_cnt_q + 32'h0000_0001;
    end
  end

  // Filter selection and texel addressing
  logic [3:0]  wlog;
  logic [3:0]  hlog;
  logic        lin;
  logic        map2d;
  logic [15:0] ui;
  logic [15:0] vi;
  logic [3:0]  wl;
  logic [3:0]  hl;
  logic [7:0]  umask;
  logic [7:0]  vmask;
  logic [7:0]  i0;
  logic [7:0]  i1;
  logic [7:0]  j0;
  logic [7:0]  j1;
  logic [3:0][7:0] ra;

  assign wlog  = tfc_q[tcw_pkg::TFC_WIDTH_LSB +: 4];
  assign hlog  = tfc_q[tcw_pkg::TFC_HEIGHT_LSB +: 4];
  assign map2d = tfc_q[tcw_pkg::TFC_MAPTYPE_BIT];
  assign wl    = (wlog > 4'h4) ? 4'h4 : wlog;
  assign hl    = (hlog > 4'h4) ? 4'h4 : hlog;
  assign umask = 8'(({4'h0, 4'hF} >> (4 - wl)));
  assign vmask = 8'(({4'h0, 4'hF} >> (4 - hl)));

  // Linear when the chosen filter blends within a level
  always_comb begin
    lin = tfc_q[tcw_pkg::TFC_MAG_BIT];
    if (minify) begin
      unique case (tfc_q[tcw_pkg::TFC_MIN_LSB +: 3])
        tcw_pkg::TCW_MIN_LINEAR, tcw_pkg::TCW_MIN_LMN, tcw_pkg::TCW_MIN_LML: lin = 1'b1;
        default: lin = 1'b0;
      endcase
    end
  end // [RQ17]

  // Integer texel index; 1.0 lands on the last texel
  assign ui = u_q[16] ? 16'hFFFF : u_q[15:0];
  assign vi = v_q[16] ? 16'hFFFF : v_q[15:0];
  assign i0 = 8'(ui >> (16 - wl)) & umask;
  assign j0 = 8'(vi >> (16 - hl)) & vmask;
  assign i1 = (i0 + 8'h01) & umask;
  assign j1 = (j0 + 8'h01) & vmask;

  // Four addresses from base, row pitch 2^width
  for (genvar k = 0; k < 4; k++) begin : g_addr
    assign ra[k] = 8'(base_q[7:0] + (((k / 2) != 0 ? j1 : j0) << wl)
                      + ((k % 2) != 0 ? i1 : i0)); // [RQ14]
  end

  // Output fields held apart so each has a single driver
  logic [3:0][31:0] texel_rd;
  logic [7:0]       coef_u_q;
  logic [7:0]       coef_v_q;
  logic [1:0]       ntex_q;

  tcw_texmem u_mem (
    .pclk  (pclk),
    .we    (tmem_we),
    .waddr (tmem_waddr),
    .wdata (tmem_wdata),
    .raddr (ra),
    .rdata (texel_rd)
  ); // [RQ15]

  // Coefficients and texel count registered alongside memory read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tex_valid <= 1'b0;
      coef_u_q  <= 8'h00;
      coef_v_q  <= 8'h00;
      ntex_q    <= 2'b00;
      tex_addr  <= '0;
    end else begin
      // tex_valid stays low while texel reads are disabled; tex_addr still updates
      tex_valid <= uv_valid_q && tfc_q[tcw_pkg::TFC_ENABLE_BIT];
      tex_addr  <= ra; // [RQ14]
      // Texel count and blend weights follow the chosen filter
      if (!lin) begin
        ntex_q   <= 2'b00; // [RQ18]
        coef_u_q <= 8'h00;
        coef_v_q <= 8'h00;
      end else if (uv_line_q || !map2d) begin
        ntex_q   <= 2'b01; // [RQ19]
        coef_u_q <= 8'((ui << wl) >> 8); // [RQ16]
        coef_v_q <= 8'h00;
      end else begin
        ntex_q   <= 2'b11; // [RQ20]
        coef_u_q <= 8'((ui << wl) >> 8); // [RQ16]
        coef_v_q <= 8'((vi << hl) >> 8); // [RQ16]
      end
    end
  end

  // Texels come straight from the memory read register
  assign tex_out = '{texel: texel_rd, coef_u: coef_u_q, coef_v: coef_v_q, ntex: ntex_q};

endmodule

//--- dv/tcw_frag_src.sv
// Upstream interpolator model feeding single fragments
`timescale 1ns/1ps
module tcw_frag_src (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               go,
  input  wire logic               frag_ready,
  input  wire tcw_pkg::tcw_frag_s req,
  output logic                    frag_valid,
  output tcw_pkg::tcw_frag_s      frag
);
  // One-cycle fragment held while refused, payload scrambled while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frag_valid <= 1'b0;
      frag       <= '0;
    end else if (!frag_valid || frag_ready) begin
      frag_valid <= go;
      frag       <= go ? req : ~frag;
    end
  end
endmodule

//--- dv/tcw_props.sv
// Port checker for the texture coordinate stage
`timescale 1ns/1ps
module tcw_props (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 frag_valid,
  input wire tcw_pkg::tcw_frag_s   frag,
  input wire logic                 minify,
  input wire logic                 tex_valid,
  input wire tcw_pkg::tcw_texout_s tex_out
);
  logic       en_q, op_q, ten_q, mag_q, map_q, line_q, wr, tk;
  logic [5:0] en_sr_q, tx_sr_q;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Accepted write and accepted fragment
  assign wr = psel && penable && pwrite && pready;
  assign tk = frag_valid && frag.tex_en && en_q && ten_q;
  // Shadow of control fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {en_q, op_q, ten_q, mag_q, map_q} <= 5'h00;
    end else if (wr && paddr == tcw_pkg::COORD_GEN_CONTROL_OFS) begin
      {en_q, op_q} <= {pwdata[0], pwdata[5]};
    end else if (wr && paddr == tcw_pkg::TEXEL_FETCH_CONTROL_OFS) begin
      {ten_q, mag_q, map_q} <= {pwdata[0], pwdata[9], pwdata[17]};
    end
  end
  // Recent fragment causes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_sr_q <= 6'h00;
      tx_sr_q <= 6'h00;
      line_q  <= 1'b0;
    end else begin
      en_sr_q <= {en_sr_q[4:0], frag_valid && en_q};
      tx_sr_q <= {tx_sr_q[4:0], frag_valid && frag.tex_en};
      line_q  <= tk ? frag.line : line_q;
    end
  end
  property p_planar;
    tk && !op_q |-> ##[2:3] tex_valid;
  endproperty
  a_planar: assert property (p_planar) else $error("planar latency");
  property p_persp;
    tk && op_q |-> ##[4:5] tex_valid;
  endproperty
  a_persp: assert property (p_persp) else $error("perspective latency");
  property p_no_en;
    tex_valid |-> (|en_sr_q);
  endproperty
  a_no_en: assert property (p_no_en) else $error("output while disabled");
  property p_no_tex;
    tex_valid |-> (|tx_sr_q);
  endproperty
  a_no_tex: assert property (p_no_tex) else $error("output without enable");
  property p_near;
    tex_valid && !minify && !mag_q |-> tex_out.ntex == 2'h0;
  endproperty
  a_near: assert property (p_near) else $error("nearest count");
  property p_bilin;
    tex_valid && !minify && mag_q && map_q && !line_q |-> tex_out.ntex == 2'h3;
  endproperty
  a_bilin: assert property (p_bilin) else $error("bilinear count");
  property p_line;
    tex_valid && !minify && mag_q && map_q && line_q |-> tex_out.ntex == 2'h1;
  endproperty
  a_line: assert property (p_line) else $error("line count");
  property p_err;
    psel && penable && paddr > tcw_pkg::STATUS_OFS |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
endmodule

bind tcw_top tcw_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .frag_valid(frag_valid), .frag(frag),
  .minify(minify), .tex_valid(tex_valid), .tex_out(tex_out));

//--- dv/tcw_top_tb.sv
// Self-checking bench for the texture coordinate stage
`timescale 1ns/1ps
module tcw_top_tb;
  localparam logic [11:0] CGC = tcw_pkg::COORD_GEN_CONTROL_OFS;
  localparam logic [11:0] TFC = tcw_pkg::TEXEL_FETCH_CONTROL_OFS;
  localparam logic [31:0] Q1  = 32'h0001_0000;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic                 go = 1'b0;
  logic                 minify = 1'b0;
  logic                 tmem_we = 1'b0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0000_0000;
  logic [7:0]           tmem_waddr = 8'h00;
  logic [31:0]          tmem_wdata = 32'h0000_0000;
  logic [31:0]          prdata, rd;
  logic                 pready, pslverr, frag_valid, frag_ready, tex_valid, hit, err;
  logic [3:0][7:0]      tex_addr, ta;
  tcw_pkg::tcw_frag_s   frag;
  tcw_pkg::tcw_frag_s   req = '0;
  tcw_pkg::tcw_texout_s tex_out, tv;
  int                   fail_count = 0;
  int                   check_count = 0;
  int                   cyc = 0;

  always #2.5 pclk = ~pclk;

  tcw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frag_valid(frag_valid),
    .frag_ready(frag_ready), .frag(frag), .minify(minify), .tmem_we(tmem_we),
    .tmem_waddr(tmem_waddr), .tmem_wdata(tmem_wdata), .tex_valid(tex_valid),
    .tex_out(tex_out), .tex_addr(tex_addr));

  tcw_frag_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .req(req),
    .frag_ready(frag_ready),
    .frag_valid(frag_valid), .frag(frag));

  task automatic stop_test;
    if (fail_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] wd(input int a);
    wd = {4{a[7:0]}};
  endfunction

  function automatic logic [31:0] tfcv(input logic mag, input logic [2:0] mn);
    tfcv = 32'h0002_A089 | {19'h0, mn, mag, 9'h0};
  endfunction

  // APB transfer held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Issue one fragment and capture any result
  task automatic frag_run(input logic [31:0] s, t, q, input logic te, ln);
    hit = 1'b0;
    req <= {s, t, q, te, ln};
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (9) begin
      @(posedge pclk);
      if (tex_valid === 1'b1 && hit === 1'b0) begin
        hit = 1'b1;
        tv = tex_out;
        ta = tex_addr;
      end
    end
  endtask

  task automatic t_fill;
    for (int a = 0; a < 256; a++) begin
      tmem_we <= 1'b1;
      tmem_waddr <= a[7:0];
      tmem_wdata <= wd(a);
      @(posedge pclk);
    end
    tmem_we <= 1'b0;
  endtask

  task automatic t_regs;
    apb(1'b0, TFC, 32'h0);
    chk("tfc_reset", tcw_pkg::TFC_RESET, rd);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b1, CGC, 32'h0000_000D);
    apb(1'b0, CGC, 32'h0);
    chk("cgc", 32'h0000_000D, rd);
    apb(1'b0, TFC, 32'h0);
    chk("fetch_wrap", 32'h6, {28'h0, rd[16:13]});
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk("slverr_wr", 32'h1, {31'h0, err});
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", {31'h0, 1'b1}, {rd[31:1], err});
  endtask

  task automatic t_planar;
    apb(1'b1, TFC, tfcv(1'b0, 3'h0));
    apb(1'b1, CGC, 32'h0000_0001);
    frag_run(32'h5800_0000, 32'h3000_0000, 32'h0004_0000, 1'b1, 1'b0);
    chk("texel", wd(53), tv.texel[0]);
    chk("addr", 32'd53, {24'h0, ta[0]});
    chk("ntex", 32'h0, {30'h0, tv.ntex});
    chk("frag_ready", 32'h1, {31'h0, frag_ready});
    apb(1'b1, CGC, 32'h0000_0000);
    frag_run(32'h5800_0000, 32'h0, Q1, 1'b1, 1'b0);
    chk("hit_off", 32'h0, {31'h0, hit});
    apb(1'b1, CGC, 32'h0000_0001);
    frag_run(32'h5800_0000, 32'h0, Q1, 1'b0, 1'b0);
    chk("hit_notex", 32'h0, {31'h0, hit});
  endtask

  task automatic wcase(input logic [1:0] h, v, input logic [31:0] s, t, q,
                       input int ei, ej);
    apb(1'b1, CGC, {26'h0, 1'b1, v, h, 1'b1});
    frag_run(s, t, q, 1'b1, 1'b0);
    chk("hit", 32'h1, {31'h0, hit});
    chk("texel", wd(ej * 16 + ei), tv.texel[0]);
  endtask

  task automatic t_wrap;
    wcase(2'h0, 2'h0, 32'h0002_8000, 32'h0, Q1, 15, 0);
    wcase(2'h0, 2'h0, 32'hFFFF_8000, 32'h0, Q1, 0, 0);
    wcase(2'h1, 2'h0, 32'h0002_4000, 32'h0, Q1, 4, 0);
    wcase(2'h1, 2'h0, 32'hFFFF_C000, 32'h0, Q1, 12, 0);
    wcase(2'h2, 2'h0, 32'h0001_4000, 32'h0, Q1, 12, 0);
    wcase(2'h2, 2'h0, 32'h0002_4000, 32'h0, Q1, 4, 0);
    wcase(2'h2, 2'h0, 32'hFFFF_C000, 32'h0, Q1, 4, 0);
    wcase(2'h0, 2'h0, 32'h0, 32'h0003_0000, Q1, 0, 15);
    wcase(2'h0, 2'h1, 32'h0, 32'h0001_C000, Q1, 0, 12);
    wcase(2'h2, 2'h1, 32'h0001_4000, 32'h0001_4000, Q1, 12, 4);
    wcase(2'h1, 2'h2, 32'h0000_C000, 32'h0001_C000, 32'h0002_0000, 6, 14);
  endtask

  task automatic t_filter;
    apb(1'b1, TFC, tfcv(1'b1, 3'h0));
    apb(1'b1, CGC, 32'h0000_0001);
    frag_run(32'h5800_0000, 32'h3800_0000, 32'h0, 1'b1, 1'b0);
    chk("ntex_bilin", 32'h3, {30'h0, tv.ntex});
    chk("coef_u", 32'h80, {24'h0, tv.coef_u});
    chk("coef_v", 32'h80, {24'h0, tv.coef_v});
    chk("texel_right", wd(54), tv.texel[1]);
    chk("texel_far", wd(70), tv.texel[3]);
    chk("addr_far", 32'h46, {24'h0, ta[3]});
    frag_run(32'h5800_0000, 32'h3000_0000, 32'h0, 1'b1, 1'b1);
    chk("ntex_line", 32'h1, {30'h0, tv.ntex});
    apb(1'b1, TFC, tfcv(1'b1, 3'h0) & 32'hFFFD_FFFF);
    frag_run(32'h5800_0000, 32'h3000_0000, 32'h0, 1'b1, 1'b0);
    chk("ntex_1d", 32'h1, {30'h0, tv.ntex});
    minify <= 1'b1;
    for (int m = 0; m < 6; m++) begin
      apb(1'b1, TFC, tfcv(1'b0, m[2:0]));
      frag_run(32'h5800_0000, 32'h3000_0000, 32'h0, 1'b1, 1'b0);
      chk("min_hit", 32'h1, {31'h0, hit});
      chk("min_ntex", (m == 1 || m >= 4) ? 32'h3 : 32'h0, {30'h0, tv.ntex});
    end
    minify <= 1'b0;
    apb(1'b0, tcw_pkg::STATUS_OFS, 32'h0);
    chk("frag_count", 32'h15, rd);
  endtask

  // Watchdog on total run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_fill();
    t_regs();
    t_planar();
    t_wrap();
    t_filter();
    stop_test();
  end
endmodule
